// ### common/fmac_regs.vh
// register offsets, field positions, reset values and timing counts of the fault mask / adc block
`ifndef FMAC_REGS_VH
`define FMAC_REGS_VH

`define FMAC_OFS_MASK_A      8'h2c
`define FMAC_OFS_MASK_B      8'h2d
`define FMAC_OFS_ADC_CTRL    8'h2e
`define FMAC_OFS_CHAN_OFF_A  8'h2f

`define FMAC_RST_MASK_A      8'h00
`define FMAC_RST_MASK_B      8'h00
`define FMAC_RST_ADC_CTRL    8'h30
`define FMAC_RST_CHAN_OFF_A  8'h00

// writable bits per register; others read zero
`define FMAC_WMASK_MASK_B    8'hfc
`define FMAC_WMASK_ADC_CTRL  8'hff
`define FMAC_WMASK_CHAN_OFF  8'hfe

`define FMAC_BIT_ADC_EN      7
`define FMAC_BIT_ADC_ONESHOT 6
`define FMAC_BIT_SPEED_HI    5
`define FMAC_BIT_SPEED_LO    4
`define FMAC_BIT_AVG_ON      3
`define FMAC_BIT_AVG_SEED    2

// adc done event index inside the event vector
`define FMAC_EV_ADC_DONE     14

// interrupt pulse width on the host line
`define FMAC_INT_PULSE_NS    256
`define FMAC_CLK_NS          40
`define FMAC_INT_PULSE_CYC   (((`FMAC_INT_PULSE_NS) + (`FMAC_CLK_NS) - 1) / (`FMAC_CLK_NS))

`endif

// ### src/fmac_pulse_gen.v
// stretches a one-cycle request into a fixed-width interrupt pulse
`timescale 1ns/10ps
module fmac_pulse_gen (
    // clock and reset
    input  wire       clock,
    input  wire       srst,
    // trigger and pulse
    input  wire       trig,
    output reg        pulse
);
`include "fmac_regs.vh"

    localparam integer WIDTH_CYC = `FMAC_INT_PULSE_CYC;
    localparam [3:0]   WIDTH     = WIDTH_CYC[3:0];

    reg [3:0] count;

    // a new trigger restarts the pulse, so back-to-back events merge into one
    always @(posedge clock) begin
        if (srst) begin
            count <= 4'h0;
            pulse <= 1'b0;
        end else if (trig) begin
            count <= WIDTH - 4'h1;
            pulse <= 1'b1;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end else begin
            pulse <= 1'b0;
        end
    end

endmodule // fmac_pulse_gen

// ### src/fmac_regs_top.v
// fault interrupt masks and adc control registers with host interrupt gating
`timescale 1ns/10ps
module fmac_regs_top (
    // clock and reset
    input  wire        clock,
    input  wire        srst,
    // register access from the serial bus engine (same clock)
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rvalid,
    // soft reset sources
    input  wire        reg_reset_cmd,
    input  wire        watchdog_expired,
    // raw protection levels from analog comparators (asynchronous)
    input  wire        batt_current_loop_active,
    input  wire        input_bus_overvolt,
    input  wire        battery_overvolt,
    input  wire        input_overcurrent,
    input  wire        battery_overcurrent,
    input  wire        converter_overcurrent,
    input  wire        source_b_overvolt,
    input  wire        source_a_overvolt,
    input  wire        system_rail_short,
    input  wire        system_rail_overvolt,
    input  wire        reverse_out_overvolt,
    input  wire        reverse_out_undervolt,
    input  wire        die_overheat_shutdown,
    input  wire        reverse_power_mode,
    // conversion done strobe from the adc sequencer (same clock)
    input  wire        adc_conv_done,
    // conversion-done mask held in a neighbouring block
    input  wire        adc_done_irq_block,
    // host interrupt pulse, active low
    output reg         host_int_n,
    // fault status, reported regardless of masks
    output reg  [12:0] fault_status,
    // adc controls
    output reg         adc_enable,
    output reg         adc_one_shot,
    output reg  [1:0]  adc_speed,
    output reg  [3:0]  adc_resolution_bits,
    output reg         meas_running_mean_on,
    output reg         meas_mean_seed_fresh,
    output reg  [7:0]  channel_off
);
`include "fmac_regs.vh"

    // register map seen from the serial bus engine
    //   0x2c  protection irq mask a: all eight bits stored, one per protection event
    //   0x2d  protection irq mask b: bits 7-2 stored, bits 1-0 tied to zero
    //   0x2e  converter sampling control: enable, one-shot, speed, mean and seed bits
    //   0x2f  channel off a: bits 7-1 stored, bit 0 tied to zero
    //   any other address is ignored on write and reads back as zero
    //
    // event vector, msb first, matching mask a bits 7-0 then mask b bits 7-4 and 2
    //   12 battery current loop    11 input bus overvolt   10 battery overvolt
    //    9 input overcurrent        8 battery overcurrent   7 converter overcurrent
    //    6 source b overvolt        5 source a overvolt     4 system rail short
    //    3 system rail overvolt     2 reverse out overvolt  1 reverse out undervolt
    //    0 die overheat shutdown
    //
    // reset sources
    //   srst loads every default, 0x30 into 0x2e, and clears the rest, the sync chains and the pulse stretcher included
    //   reg_reset_cmd reloads the four register bytes only; a pulse already on
    //   the host line runs out, so the host never sees a clipped pulse
    //   watchdog_expired clears only the converter enable bit; against a host write
    //   to 0x2e in the same cycle the clear wins, so a stuck host cannot keep the
    //   converter running past an expiry
    //
    // event path timing, in clock edges from a comparator change
    //   two edges through the synchroniser, one into the stretcher and one into the
    //   output flop: the host line falls four cycles after the comparator and stays
    //   low seven cycles; a conversion-done strobe skips the synchroniser and shows
    //   two cycles after its strobe
    //
    // limitations
    //   events closer than the pulse width merge into one longer pulse, so the host
    //   must read the status to learn which events occurred
    //   a comparator level shorter than one clock may be missed altogether, which
    //   is fine while protection levels are held far longer than that
    //   reverse-out faults only interrupt while reverse power mode is synced high

    localparam NEV = 13;

    // register bytes as the host sees them
    reg  [7:0]     protection_irq_mask_a;
    reg  [7:0]     protection_irq_mask_b;
    reg  [7:0]     converter_sampling_control;
    reg  [7:0]     measurement_channel_off_a;

    // synchroniser chains and edge history
    reg  [NEV-1:0] sync1;
    reg  [NEV-1:0] sync2;
    reg  [NEV-1:0] prev;
    reg            sync1_rev;
    reg            sync2_rev;

    // combinational event terms
    reg  [NEV-1:0] ev;
    reg  [NEV-1:0] blk;
    reg  [NEV-1:0] rise;
    reg            done_ok;
    reg            any_event;
    wire [NEV-1:0] gated;

    // glue nets
    wire           pulse;
    wire [NEV-1:0] raw;
    wire           soft_rst;

    assign soft_rst = srst | reg_reset_cmd;
    assign raw = {batt_current_loop_active, input_bus_overvolt, battery_overvolt,
                  input_overcurrent, battery_overcurrent, converter_overcurrent,
                  source_b_overvolt, source_a_overvolt, system_rail_short,
                  system_rail_overvolt, reverse_out_overvolt, reverse_out_undervolt,
                  die_overheat_shutdown};

    // maps the speed code to effective resolution in bits
    // slower sampling buys resolution: code 0 is the finest, code 3 the coarsest
    function [3:0] speed_to_bits;
        input [1:0] code;
        begin
            speed_to_bits = 4'hf - {2'b00, code};
        end
    endfunction

    // address decode, used by write and read paths
    // only meaningful once in_range has accepted the address
    function [1:0] reg_index;
        input [7:0] a;
        begin
            reg_index = a[1:0];
        end
    endfunction

    // window test on the whole byte, so aliases of the low two bits are refused
    function in_range;
        input [7:0] a;
        begin
            in_range = (a >= `FMAC_OFS_MASK_A) && (a <= `FMAC_OFS_CHAN_OFF_A);
        end
    endfunction

    // two-stage synchronisers on every comparator level
    // the comparators have no timing relation to this clock; only the second
    // stage may be read, prev keeps the last synced level for the edge detector
    always @(posedge clock) begin
        if (srst) begin
            sync1     <= 13'h0000;
            sync2     <= 13'h0000;
            prev      <= 13'h0000;
            sync1_rev <= 1'b0;
            sync2_rev <= 1'b0;
        end else begin
            sync1     <= raw;
            sync2     <= sync1;
            prev      <= sync2;
            sync1_rev <= reverse_power_mode;
            sync2_rev <= sync1_rev;
        end
    end

    // event detection; current loop reports both edges, others entry only
    // reverse-out faults also need the synced reverse mode flag
    // blk lines up bit for bit with ev, see the event vector map above
    always @* begin
        rise    = sync2 & ~prev;
        ev      = rise;
        ev[12]  = sync2[12] ^ prev[12];
        ev[2]   = rise[2] & sync2_rev;
        ev[1]   = rise[1] & sync2_rev;
        blk     = {protection_irq_mask_a,
                   protection_irq_mask_b[7:4],
                   protection_irq_mask_b[2]};
        done_ok = adc_conv_done & converter_sampling_control[`FMAC_BIT_ADC_ONESHOT]
                  & ~adc_done_irq_block;
    end

    // per-event gate; a set mask bit removes the pulse request and nothing else
    genvar gi;
    generate
        for (gi = 0; gi < NEV; gi = gi + 1) begin : g_gate
            assign gated[gi] = ev[gi] & ~blk[gi];
        end
    endgenerate

    // one shared request for the stretcher; simultaneous events share one pulse
    always @* begin
        any_event = (|gated) | done_ok;
    end

    // register file; watchdog clears only the adc enable bit
    // register reset reloads all four bytes, srst included through soft_rst
    // write data is masked here so reserved bits never hold a one
    always @(posedge clock) begin
        if (soft_rst) begin
            protection_irq_mask_a      <= `FMAC_RST_MASK_A;
            protection_irq_mask_b      <= `FMAC_RST_MASK_B;
            converter_sampling_control <= `FMAC_RST_ADC_CTRL;
            measurement_channel_off_a  <= `FMAC_RST_CHAN_OFF_A;
        end else begin
            if (reg_wr && in_range(reg_addr)) begin
                case (reg_index(reg_addr))
                    2'h0: begin
                        protection_irq_mask_a <= reg_wdata;
                    end
                    2'h1: begin
                        protection_irq_mask_b <= reg_wdata & `FMAC_WMASK_MASK_B;
                    end
                    2'h2: begin
                        converter_sampling_control <= reg_wdata & `FMAC_WMASK_ADC_CTRL;
                    end
                    2'h3: begin
                        measurement_channel_off_a <= reg_wdata & `FMAC_WMASK_CHAN_OFF;
                    end
                    default: begin
                        protection_irq_mask_a <= protection_irq_mask_a;
                    end
                endcase
            end
            if (watchdog_expired) begin
                converter_sampling_control[`FMAC_BIT_ADC_EN] <= 1'b0;
            end
        end
    end

    // read path, one cycle latency; unmapped addresses read zero
    // rvalid follows every read strobe, unmapped or not, so the bus engine
    // always gets an answer on the next cycle
    always @(posedge clock) begin
        if (srst) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd && in_range(reg_addr)) begin
                case (reg_index(reg_addr))
                    2'h0: begin
                        reg_rdata <= protection_irq_mask_a;
                    end
                    2'h1: begin
                        reg_rdata <= protection_irq_mask_b;
                    end
                    2'h2: begin
                        reg_rdata <= converter_sampling_control;
                    end
                    default: begin
                        reg_rdata <= measurement_channel_off_a;
                    end
                endcase
            end else begin
                reg_rdata <= 8'h00;
            end
        end
    end

    // status and controls are registered; masks never touch status
    // each control output is a flop copy of its register bits, adc_resolution_bits a decode of the speed bits, one cycle late,
    // and srst loads the same defaults the register bytes take
    always @(posedge clock) begin
        if (srst) begin
            fault_status         <= 13'h0000;
            adc_enable           <= 1'b0;
            adc_one_shot         <= 1'b0;
            adc_speed            <= 2'h3;
            adc_resolution_bits  <= 4'hc;
            meas_running_mean_on <= 1'b0;
            meas_mean_seed_fresh <= 1'b0;
            channel_off          <= 8'h00;
        end else begin
            fault_status         <= sync2;
            adc_enable           <= converter_sampling_control[`FMAC_BIT_ADC_EN];
            adc_one_shot         <= converter_sampling_control[`FMAC_BIT_ADC_ONESHOT];
            adc_speed            <= converter_sampling_control[5:4];
            adc_resolution_bits  <= speed_to_bits(converter_sampling_control[5:4]);
            meas_running_mean_on <= converter_sampling_control[`FMAC_BIT_AVG_ON];
            meas_mean_seed_fresh <= converter_sampling_control[`FMAC_BIT_AVG_SEED];
            channel_off          <= measurement_channel_off_a;
        end
    end

    // host line flop, kept apart so the pin sees nothing but the stretcher;
    // the line idles high, so reset releases it rather than firing a pulse
    always @(posedge clock) begin
        if (srst) begin
            host_int_n <= 1'b1;
        end else begin
            host_int_n <= ~pulse;
        end
    end

    // pulse stretcher for the host line
    // it sees srst only, so a register reset cannot clip a pulse already on the line
    fmac_pulse_gen u_pulse (
        .clock (clock),
        .srst  (srst),
        .trig  (any_event),
        .pulse (pulse)
    );

endmodule // fmac_regs_top

// ### tb/fmac_host.sv
// host model issuing single-byte register strobes
`timescale 1ns/10ps
module fmac_host (
    // clock
    input  wire       clock,
    // strobes toward the block, idle at time zero
    output reg  [7:0] reg_addr = 8'h00,
    output reg        reg_wr = 1'b0,
    output reg        reg_rd = 1'b0,
    output reg  [7:0] reg_wdata = 8'h00,
    // read answer
    input  wire [7:0] reg_rdata,
    input  wire       reg_rvalid
);
    // strobe held one edge; released data is inverted so stale values never match
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clock) #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clock) #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    // answer taken one cycle after the read edge
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clock) #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock) #1;
        reg_rd = 1'b0;
        d = reg_rvalid ? reg_rdata : 8'hxx;
    endtask
endmodule // fmac_host

// ### tb/fmac_regs_asserts.sv
// concurrent checks on the ports of the fault mask and adc register block
`timescale 1ns/10ps
module fmac_regs_asserts (
    // clock and reset
    input wire       clock,
    input wire       srst,
    // register strobes and answer
    input wire [7:0] reg_addr,
    input wire       reg_wr,
    input wire [7:0] reg_wdata,
    input wire [7:0] reg_rdata,
    input wire       reg_rvalid,
    // events, interrupt and controls
    input wire       reg_reset_cmd,
    input wire       watchdog_expired,
    input wire       adc_conv_done,
    input wire       adc_done_irq_block,
    input wire       host_int_n,
    input wire       adc_enable,
    input wire       adc_one_shot,
    input wire [1:0] adc_speed,
    input wire [7:0] channel_off
);
    // write fields, followed two cycles later on the control outputs
    wire [2:0] wd_ctl = reg_wdata[6:4];
    wire [6:0] wd_chan = reg_wdata[7:1];
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    property p_unmapped; reg_rvalid && ($past(reg_addr) < 8'h2c || $past(reg_addr) > 8'h2f)
        |-> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_resv; reg_rvalid && $past(reg_addr) == 8'h2d |-> reg_rdata[1:0] == 2'b00; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits not zero");
    property p_wdog; watchdog_expired |-> ##2 !adc_enable; endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog left adc on");
    property p_rrst; reg_reset_cmd |-> ##2 adc_speed == 2'h3 && !adc_enable; endproperty
    a_rrst: assert property (p_rrst) else $error("register reset missed");
    property p_ctl; reg_wr && reg_addr == 8'h2e && !reg_reset_cmd
        |-> ##2 {adc_one_shot, adc_speed} == $past(wd_ctl, 2); endproperty
    a_ctl: assert property (p_ctl) else $error("adc controls not copied");
    property p_chan; reg_wr && reg_addr == 8'h2f && !reg_reset_cmd
        |-> ##2 channel_off == {$past(wd_chan, 2), 1'b0}; endproperty
    a_chan: assert property (p_chan) else $error("channel off not copied");
    property p_pulse; $fell(host_int_n) |-> (!host_int_n)[*7]; endproperty
    a_pulse: assert property (p_pulse) else $error("interrupt pulse short");
    property p_done; adc_conv_done && adc_one_shot && !adc_done_irq_block
        |-> ##[1:3] !host_int_n; endproperty
    a_done: assert property (p_done) else $error("done pulse missing");
    c_done: cover property (adc_conv_done && adc_one_shot);
    c_int: cover property ($fell(host_int_n));
    c_wdog: cover property (watchdog_expired);
endmodule // fmac_regs_asserts

// ### tb/testbench.sv
// self-checking bench for the fault mask and adc control register block
`timescale 1ns/10ps
module testbench;
    reg         clock, srst, rrc, wdx, done, dblk, rpm;
    reg  [12:0] flt;
    reg  [31:0] rs;
    reg  [7:0]  v, wa, wb, seen, e, m [0:4];
    wire [7:0]  addr, wdata, rdata, choff;
    wire [12:0] fst;
    wire [3:0]  res;
    wire [1:0]  spd;
    wire        wr, rd, rvalid, int_n, en, osh, avg, seed;
    integer     fail_count, checks, i, k;
    function [31:0] xs(input [31:0] x);
        xs = x ^ (x << 13);
        xs = xs ^ (xs >> 17);
        xs = xs ^ (xs << 5);
    endfunction
    task chk(input [63:0] n, input [7:0] e, input [7:0] g);
        checks = checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("ERROR %0s expected %h seen %h", n, e, g);
        end
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // one protection event; when open, every other mask bit is set to catch a wrong mapping
    task ftest(input integer f, input integer blk);
        wa = (f > 4) ? 8'h01 << (f - 5) : 8'h00;
        wb = (f == 0) ? 8'h04 : (f < 5) ? 8'h01 << (f + 3) : 8'h00;
        fmac_host_inst.wr(8'h2c, blk ? wa : ~wa);
        fmac_host_inst.wr(8'h2d, blk ? wb : ~wb & 8'hfc);
        flt[f] = 1'b1;
        seen = 8'h00;
        repeat (12) @(posedge clock) #1 seen = seen | {7'h00, ~int_n};
        e = (blk != 0 || (rpm == 1'b0 && (f == 1 || f == 2))) ? 8'h00 : 8'h01;
        chk("irq", e, seen);
        chk("status", 8'h01, {7'h00, fst[f]});
        flt[f] = 1'b0;
        seen = 8'h00;
        repeat (14) @(posedge clock) #1 seen = seen | {7'h00, ~int_n};
        e = (blk == 0 && f == 12) ? 8'h01 : 8'h00;
        chk("irqexit", e, seen);
    endtask
    fmac_host fmac_host_inst (.clock(clock), .reg_addr(addr), .reg_wr(wr), .reg_rd(rd),
        .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid));
    fmac_regs_top fmac_regs_top_inst (.clock(clock), .srst(srst), .reg_addr(addr),
        .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .reg_reset_cmd(rrc), .watchdog_expired(wdx), .batt_current_loop_active(flt[12]),
        .input_bus_overvolt(flt[11]), .battery_overvolt(flt[10]), .input_overcurrent(flt[9]),
        .battery_overcurrent(flt[8]), .converter_overcurrent(flt[7]),
        .source_b_overvolt(flt[6]), .source_a_overvolt(flt[5]), .system_rail_short(flt[4]),
        .system_rail_overvolt(flt[3]), .reverse_out_overvolt(flt[2]),
        .reverse_out_undervolt(flt[1]), .die_overheat_shutdown(flt[0]),
        .reverse_power_mode(rpm), .adc_conv_done(done), .adc_done_irq_block(dblk),
        .host_int_n(int_n), .fault_status(fst), .adc_enable(en), .adc_one_shot(osh),
        .adc_speed(spd), .adc_resolution_bits(res), .meas_running_mean_on(avg),
        .meas_mean_seed_fresh(seed), .channel_off(choff));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // the sequence needs under 2000 cycles
    initial begin
        #(40 * 4000);
        fail_count = fail_count + 1;
        summarize;
    end
    initial begin
        {srst, rrc, wdx, done, dblk, rpm, flt} = {6'b100001, 13'h0000};
        fail_count = 0;
        checks = 0;
        rs = 32'h701b43e6;
        for (i = 0; i < 5; i = i + 1) m[i] = (i == 2) ? 8'h30 : 8'h00;
        repeat (4) @(posedge clock);
        #1 srst = 1'b0;
        // reset values, then random bytes through the writable bits, unmapped 0x30 included
        for (k = 0; k < 2; k = k + 1)
            for (i = 0; i < 5; i = i + 1) begin
                fmac_host_inst.rd(8'h2c + i[7:0], v);
                chk("reg", m[i], v);
                rs = xs(rs);
                m[i] = rs[7:0] & (i == 1 ? 8'hfc : i == 3 ? 8'hfe : i == 4 ? 8'h00 : 8'hff);
                fmac_host_inst.wr(8'h2c + i[7:0], rs[7:0]);
            end
        chk("choff", m[3], choff);
        $display("register test done");
        for (k = 0; k < 4; k = k + 1) begin
            rs = xs(rs);
            v = {k[0], rs[6], k[1:0], rs[3:0]};
            m[2] = v;
            fmac_host_inst.wr(8'h2e, v);
            @(posedge clock) #1;
            chk("adcctl", {2'b00, v[7:2]}, {2'b00, en, osh, spd, avg, seed});
            chk("resol", 8'd15 - k[7:0], {4'h0, res});
        end
        @(posedge clock) #1 wdx = 1'b1;
        @(posedge clock) #1 wdx = 1'b0;
        fmac_host_inst.rd(8'h2e, v);
        chk("watchdog", m[2] & 8'h7f, v);
        $display("adc control test done");
        for (k = 0; k < 3; k = k + 1) begin
            dblk = (k == 1);
            fmac_host_inst.wr(8'h2e, k == 2 ? 8'hb0 : 8'hf0);
            repeat (3) @(posedge clock);
            #1 done = 1'b1;
            @(posedge clock) #1 done = 1'b0;
            seen = 8'h00;
            repeat (10) @(posedge clock) #1 seen = seen | {7'h00, ~int_n};
            chk("doneirq", k == 0 ? 8'h01 : 8'h00, seen);
        end
        $display("conversion done test done");
        @(posedge clock) #1 rrc = 1'b1;
        @(posedge clock) #1 rrc = 1'b0;
        for (i = 0; i < 5; i = i + 1) m[i] = (i == 2) ? 8'h30 : 8'h00;
        for (i = 0; i < 5; i = i + 1) begin
            fmac_host_inst.rd(8'h2c + i[7:0], v);
            chk("regrst", m[i], v);
        end
        $display("register reset test done");
        for (k = 12; k >= 0; k = k - 1) begin
            ftest(k, 0);
            ftest(k, 1);
        end
        // reverse-out faults with reverse mode off must stay silent even when open
        @(posedge clock) #1 rpm = 1'b0;
        ftest(2, 0);
        ftest(1, 0);
        $display("interrupt mask test done");
        summarize;
    end
endmodule // testbench
bind fmac_regs_top fmac_regs_asserts fmac_regs_asserts_inst (.clock(clock), .srst(srst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_reset_cmd(reg_reset_cmd),
    .watchdog_expired(watchdog_expired), .adc_conv_done(adc_conv_done),
    .adc_done_irq_block(adc_done_irq_block), .host_int_n(host_int_n),
    .adc_enable(adc_enable), .adc_one_shot(adc_one_shot), .adc_speed(adc_speed),
    .channel_off(channel_off));
